/* include/igc_pkg.sv */
// constants and types for the indicator and global configuration block
// assumes a single 50 MHz clock and register strobes from the serial front end
`default_nettype none

package igc_pkg;

	// ************************************************************
	// register map
	// ************************************************************
	localparam int         DATA_W            = 8;
	localparam int         ADDR_W            = 8;
	localparam logic [7:0] OFF_GLOBAL        = 8'h0b;
	localparam logic [7:0] OFF_INDICATOR     = 8'h0c;
	localparam logic [7:0] OFF_PRIMARY_FAULT = 8'h1c;
	localparam logic [7:0] GLOBAL_RESET      = 8'h10;
	localparam logic [7:0] GLOBAL_WMASK      = 8'hf9; // bits 2:1 reserved, read zero
	localparam logic [7:0] INDICATOR_RESET   = 8'h00;
	localparam logic [7:0] FAULT_RESET       = 8'h00;
	localparam logic [7:0] READ_NONE         = 8'h00;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int BIT_PUSH_PULL   = 7;
	localparam int BIT_AUTO_SELECT = 6;
	localparam int BIT_NINTH       = 5;
	localparam int BIT_CLR_POLICY  = 4;
	localparam int BIT_FILTER_HOLD = 3;
	localparam int BIT_REF_SHORT   = 0;
	localparam int FLT_THERMAL     = 0;
	localparam int FLT_SECONDARY   = 1;
	localparam int FLT_SUPPLY_LOW  = 2;

	// ************************************************************
	// matrix geometry and scan timing
	// ************************************************************
	localparam int         MTX_N           = 3;
	localparam int         LINES           = 6;
	localparam int         INPUTS          = 8;
	localparam int         LEDS            = 9;
	localparam logic [5:0] ALL_DRIVEN      = 6'h3f;
	localparam logic [5:0] NONE_DRIVEN     = 6'h00;
	localparam logic [2:0] FIRST_ROW       = 3'h1;
	localparam int         CLK_PERIOD_NS   = 20;
	localparam int         SCAN_ROW_NS     = 1000000;
	localparam int         SCAN_ROW_CYCLES = SCAN_ROW_NS / CLK_PERIOD_NS;
	localparam int         CNT_W           = 24;

	typedef enum logic [1:0] {ROW_TOP, ROW_MID, ROW_BOT} igc_row_t;

endpackage

`default_nettype wire

/* include/igc_scan_if.sv */
// interface carrying the active matrix row from the scanner to the line logic
// assumes both ends share clock_i
`default_nettype none

interface igc_scan_if;
	logic [2:0] row_onehot; // one bit per matrix row, exactly one set
	modport drv (output row_onehot);
	modport use_row (input row_onehot);
endinterface

`default_nettype wire

/* logic/igc_scan.sv */
// row scanner for the three-by-three indicator matrix
// assumes ROW_CYCLES of at least two; rows step top, middle, bottom, repeat
`default_nettype none

module igc_scan #(
	parameter int unsigned ROW_CYCLES = igc_pkg::SCAN_ROW_CYCLES
) (
	// clock and reset
	input  wire logic  clock_i,
	input  wire logic  rst_n_i,
	// row out
	igc_scan_if.drv    scan
);

	typedef struct packed {
		igc_pkg::igc_row_t          row;
		logic [igc_pkg::CNT_W-1:0]  cnt;
		logic [2:0]                 onehot;
	} igc_scan_state_t;

	igc_scan_state_t s;
	igc_scan_state_t next_s;
	logic            last;

	assign last = (s.cnt == igc_pkg::CNT_W'(ROW_CYCLES - 1));

	// ************************************************************
	// row stepping
	// ************************************************************
	// one row lit at a time; rate well above flicker fusion
	always_comb begin
		next_s     = s;
		next_s.cnt = last ? '0 : s.cnt + 1'b1;
		unique case (s.row)
			igc_pkg::ROW_TOP: if (last) next_s.row = igc_pkg::ROW_MID;
			igc_pkg::ROW_MID: if (last) next_s.row = igc_pkg::ROW_BOT;
			igc_pkg::ROW_BOT: if (last) next_s.row = igc_pkg::ROW_TOP;
			default:          next_s.row = igc_pkg::ROW_TOP; // recover from illegal code
		endcase
		next_s.onehot = igc_pkg::FIRST_ROW << next_s.row;
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s.row    <= igc_pkg::ROW_TOP;
			s.cnt    <= '0;
			s.onehot <= igc_pkg::FIRST_ROW;
		end else begin
			s <= next_s;
		end
	end

	assign scan.row_onehot = s.onehot;

	// ************************************************************
	// checks
	// ************************************************************
	sequence s_top_ending;
		s.row == igc_pkg::ROW_TOP && last;
	endsequence
	sequence s_mid_entered;
		s.row == igc_pkg::ROW_MID && s.onehot == 3'h2;
	endsequence

	chk_row_step:
	assert property (@(posedge clock_i) disable iff (!rst_n_i)
		s_top_ending |=> s_mid_entered)
	else $error("scan did not step from top row to middle row");

	chk_row_onehot:
	assert property (@(posedge clock_i) disable iff (!rst_n_i)
		$onehot(s.onehot) && !last |=> $stable(s.onehot))
	else $error("scan row changed before its dwell ended");

endmodule // igc_scan

`default_nettype wire

/* logic/igc_top.sv */
// indicator matrix / push-pull output driver with global configuration register
// assumes register strobes and status inputs are synchronous single-cycle pulses
`default_nettype none

// How it works
// - user mode: nine indicators come from indicator register plus ninth global bit
// - autonomous mode: indicators one to eight follow the filtered input states
// - autonomous mode: ninth indicator follows the field supply low fault flag
// - ninth indicator bit lights it only when push-pull and autonomous both clear
// - policy zero: good command clears primary faults except thermal shutdown and secondary summary
// - policy zero: secondary summary clears once secondary read cleared its bits
// - policy one: primary faults stay set until the primary register is read
// - filter hold bit forces all glitch filters to mid-scale while set
// - reference pin short detection runs only while its enable bit is one
// - indicator bits seven and six drive indicators eight and seven in user mode
// - bit five drives sixth indicator, or line six level in push-pull mode
// - push-pull clear: six lines are open-drain matrix drivers
// - push-pull set: lines follow indicator bits zero to five, autonomous ignored
module igc_top #(
	parameter int unsigned ROW_CYCLES = igc_pkg::SCAN_ROW_CYCLES
) (
	// clock and reset
	input  wire logic        clock_i,
	input  wire logic        rst_n_i,
	// register access
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic [7:0]  reg_wdata_i,
	input  wire logic        cmd_ok_i,
	output logic      [7:0]  reg_rdata_o,
	// device status
	input  wire logic [7:0]  inputs_state_i,
	input  wire logic [7:0]  fault_event_i,
	input  wire logic        secondary_cleared_i,
	// output lines
	output logic      [5:0]  line_out_o,
	output logic      [5:0]  line_oe_o,
	// configuration out
	output logic             filter_hold_o,
	output logic             ref_short_detect_en_o,
	output logic      [7:0]  primary_fault_o
);

	typedef struct packed {
		logic [7:0] glob;
		logic [7:0] ind;
		logic [7:0] fault;
		logic [5:0] line_out;
		logic [5:0] line_oe;
		logic [7:0] rdata;
	} igc_state_t;

	igc_state_t s;
	igc_state_t next_s;

	igc_scan_if scan ();

	igc_scan #(
		.ROW_CYCLES (ROW_CYCLES)
	) u_scan (
		.clock_i (clock_i),
		.rst_n_i (rst_n_i),
		.scan    (scan.drv)
	);

	// ************************************************************
	// decode and mode
	// ************************************************************
	logic       wr_glob;
	logic       wr_ind;
	logic       rd_fault;
	logic       pp;
	logic       auto_sel;
	logic       policy;
	logic [8:0] lit;
	logic [7:0] clr_mask;
	logic [2:0] col_on;

	assign wr_glob  = reg_wr_i && (reg_addr_i == igc_pkg::OFF_GLOBAL);
	assign wr_ind   = reg_wr_i && (reg_addr_i == igc_pkg::OFF_INDICATOR);
	assign rd_fault = reg_rd_i && (reg_addr_i == igc_pkg::OFF_PRIMARY_FAULT);
	assign pp       = s.glob[igc_pkg::BIT_PUSH_PULL];
	assign auto_sel = s.glob[igc_pkg::BIT_AUTO_SELECT];
	assign policy   = s.glob[igc_pkg::BIT_CLR_POLICY];

	// indicator sources; the ninth bit is ignored whenever autonomous is on
	assign lit = auto_sel ? {s.fault[igc_pkg::FLT_SUPPLY_LOW], inputs_state_i}
	                      : {s.glob[igc_pkg::BIT_NINTH], s.ind};

	// ************************************************************
	// per-bit fault clear and per-column drive
	// ************************************************************
	// thermal shutdown survives routine commands so it cannot be lost silently
	for (genvar i = 0; i < igc_pkg::DATA_W; i++) begin : g_clr
		if (i == igc_pkg::FLT_THERMAL) begin : g_th
			assign clr_mask[i] = policy & rd_fault;
		end else if (i == igc_pkg::FLT_SECONDARY) begin : g_sec
			assign clr_mask[i] = policy ? rd_fault : secondary_cleared_i;
		end else begin : g_oth
			assign clr_mask[i] = policy ? rd_fault : cmd_ok_i;
		end
	end

	// column pulled low when the indicator at the active row and this column is lit
	for (genvar c = 0; c < igc_pkg::MTX_N; c++) begin : g_col
		assign col_on[c] = |(scan.row_onehot &
			{lit[2*igc_pkg::MTX_N+c], lit[igc_pkg::MTX_N+c], lit[c]});
	end

	// ************************************************************
	// next state
	// ************************************************************
	// events win over clears arriving in the same cycle
	always_comb begin
		next_s = s;
		if (wr_glob) begin
			next_s.glob = reg_wdata_i & igc_pkg::GLOBAL_WMASK;
		end
		if (wr_ind) begin
			next_s.ind = reg_wdata_i;
		end
		next_s.fault = fault_event_i | (s.fault & ~clr_mask);
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				igc_pkg::OFF_GLOBAL:        next_s.rdata = s.glob;
				igc_pkg::OFF_INDICATOR:     next_s.rdata = s.ind;
				igc_pkg::OFF_PRIMARY_FAULT: next_s.rdata = s.fault;
				default:                    next_s.rdata = igc_pkg::READ_NONE;
			endcase
		end
		if (pp) begin
			next_s.line_out = s.ind[igc_pkg::LINES-1:0];
			next_s.line_oe  = igc_pkg::ALL_DRIVEN;
		end else begin
			// open drain: only ever pull low; the active row is released high
			next_s.line_out = igc_pkg::NONE_DRIVEN;
			next_s.line_oe  = {col_on, ~scan.row_onehot};
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s.glob     <= igc_pkg::GLOBAL_RESET;
			s.ind      <= igc_pkg::INDICATOR_RESET;
			s.fault    <= igc_pkg::FAULT_RESET;
			s.line_out <= igc_pkg::NONE_DRIVEN;
			s.line_oe  <= igc_pkg::NONE_DRIVEN;
			s.rdata    <= igc_pkg::READ_NONE;
		end else begin
			s <= next_s;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign reg_rdata_o           = s.rdata;
	assign line_out_o            = s.line_out;
	assign line_oe_o             = s.line_oe;
	assign filter_hold_o         = s.glob[igc_pkg::BIT_FILTER_HOLD];
	assign ref_short_detect_en_o = s.glob[igc_pkg::BIT_REF_SHORT];
	assign primary_fault_o       = s.fault;

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);

	logic wd_hold;
	logic wd_short;
	assign wd_hold  = reg_wdata_i[igc_pkg::BIT_FILTER_HOLD];
	assign wd_short = reg_wdata_i[igc_pkg::BIT_REF_SHORT];

	sequence s_user_bottom;
		!pp && !auto_sel && scan.row_onehot[2];
	endsequence
	sequence s_auto_top;
		!pp && auto_sel && scan.row_onehot[0];
	endsequence

	chk_push_pull_lines:
	assert property (pp |=> line_out_o == $past(s.ind[5:0]) && line_oe_o == 6'h3f)
	else $error("push-pull lines do not follow indicator bits");

	chk_open_drain:
	assert property (!pp |=> line_out_o == 6'h00 && line_oe_o[2:0] == ~$past(scan.row_onehot))
	else $error("matrix lines not open drain with active row released");

	chk_user_ninth:
	assert property (s_user_bottom |=> line_oe_o[5] == $past(s.glob[igc_pkg::BIT_NINTH]))
	else $error("ninth indicator does not follow its control bit");

	chk_user_upper:
	assert property (s_user_bottom |=> line_oe_o[4:3] == $past(s.ind[7:6]))
	else $error("indicators eight and seven do not follow register bits");

	chk_auto_inputs:
	assert property (s_auto_top |=> line_oe_o[5:3] == $past(inputs_state_i[2:0]))
	else $error("autonomous indicators do not follow input states");

	chk_auto_ninth:
	assert property (!pp && auto_sel && scan.row_onehot[2]
		|=> line_oe_o[5] == $past(s.fault[igc_pkg::FLT_SUPPLY_LOW]))
	else $error("autonomous ninth indicator does not follow supply low flag");

	chk_hold_follow:
	assert property (wr_glob |=> filter_hold_o == $past(wd_hold) ##1 filter_hold_o == $past(wd_hold, 2) || $past(wr_glob))
	else $error("filter hold output does not follow written bit");

	chk_short_enable:
	assert property (wr_glob |=> ref_short_detect_en_o == $past(wd_short))
	else $error("short detect enable does not follow written bit");

	chk_auto_clear:
	assert property (!policy && cmd_ok_i && !fault_event_i[2] |=> !primary_fault_o[2])
	else $error("fault bit not cleared by successful command");

	chk_thermal_keep:
	assert property (!policy && s.fault[0] |=> primary_fault_o[0])
	else $error("thermal flag cleared under automatic policy");

	chk_summary_keep:
	assert property (!policy && s.fault[1] && !secondary_cleared_i |=> primary_fault_o[1])
	else $error("secondary summary cleared before secondary register cleared");

	chk_sticky_read:
	assert property (policy && !rd_fault && s.fault[2] |=> primary_fault_o[2])
	else $error("fault cleared without primary register read");

endmodule // igc_top

`default_nettype wire

/* test/igc_host_model.sv */
// host side model: serial front end handing register strobes to the block
// assumes the bench calls xfer from one process, synchronous to clock_i
`default_nettype none

module igc_host_model (
	// clock
	input  wire logic       clock_i,
	// register strobes
	output logic            reg_wr_o,
	output logic            reg_rd_o,
	output logic      [7:0] reg_addr_o,
	output logic      [7:0] reg_wdata_o,
	output logic            cmd_ok_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle at time zero
	initial begin
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_addr_o = 8'h00;
		reg_wdata_o = 8'h00;
		cmd_ok_o = 1'b0;
	end

	// one strobe cycle, then the good-frame pulse; gap lets a slow host stall
	// released bus shows the inverse so a stale value is never mistaken for data
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
			input logic ok, input int gap);
		@(posedge clock_i);
		reg_wr_o <= wr;
		reg_rd_o <= !wr;
		reg_addr_o <= a;
		reg_wdata_o <= d;
		@(posedge clock_i);
		reg_wr_o <= 1'b0;
		reg_rd_o <= 1'b0;
		reg_addr_o <= ~a;
		reg_wdata_o <= ~d;
		cmd_ok_o <= ok;
		@(posedge clock_i);
		cmd_ok_o <= 1'b0;
		repeat (gap) @(posedge clock_i);
	endtask
endmodule // igc_host_model

`default_nettype wire

/* test/indicator_and_global_config_test.sv */
// self-checking bench for the indicator and global configuration block
// assumes the host model for register traffic and a short scan row
`default_nettype none

module indicator_and_global_config_test;
	timeunit 1ns;
	timeprecision 1ps;

	// ************************************************************
	// signals
	// ************************************************************
	localparam int unsigned ROWS = 4; // short rows keep the run brief
	logic        clock_i;
	logic        rst_n_i;
	logic        reg_wr_i;
	logic        reg_rd_i;
	logic        cmd_ok_i;
	logic        secondary_cleared_i;
	logic        filter_hold_o;
	logic        ref_short_detect_en_o;
	logic        rd_seen = 1'b0;
	logic [7:0]  reg_addr_i;
	logic [7:0]  reg_wdata_i;
	logic [7:0]  reg_rdata_o;
	logic [7:0]  inputs_state_i;
	logic [7:0]  fault_event_i;
	logic [7:0]  primary_fault_o;
	logic [5:0]  line_out_o;
	logic [5:0]  line_oe_o;
	logic [31:0] seed = 32'he191;
	logic [31:0] d;
	logic [7:0]  exp_q[$];
	int          fails = 0;
	int          compares = 0;

	igc_top #(.ROW_CYCLES(ROWS)) dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .cmd_ok_i(cmd_ok_i), .reg_rdata_o(reg_rdata_o),
		.inputs_state_i(inputs_state_i), .fault_event_i(fault_event_i),
		.secondary_cleared_i(secondary_cleared_i), .line_out_o(line_out_o),
		.line_oe_o(line_oe_o), .filter_hold_o(filter_hold_o),
		.ref_short_detect_en_o(ref_short_detect_en_o),
		.primary_fault_o(primary_fault_o));

	igc_host_model host (.clock_i(clock_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
		.reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i), .cmd_ok_o(cmd_ok_i));

	// ************************************************************
	// helpers
	// ************************************************************
	// 50 MHz clock
	initial begin
		clock_i = 1'b0;
		forever #10 clock_i = ~clock_i;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		compares++;
		if (seen !== want) begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask

	task automatic tally_and_finish();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// read data lands one cycle after the strobe edge; match it to the oldest note
	always @(posedge clock_i) begin
		rd_seen <= reg_rd_i;
		if (rd_seen === 1'b1)
			check(reg_rdata_o, (exp_q.size() > 0) ? exp_q.pop_front() : ~reg_rdata_o);
	end

	task automatic rd(input logic [7:0] a, input logic [7:0] want);
		exp_q.push_back(want);
		host.xfer(1'b0, a, 8'h00, 1'b1, 0);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		host.xfer(1'b1, a, v, 1'b1, 1);
	endtask

	task automatic pulse_fault(input logic [7:0] f);
		@(posedge clock_i);
		fault_event_i <= f;
		@(posedge clock_i);
		fault_event_i <= 8'h00;
		repeat (2) @(posedge clock_i);
	endtask

	// watch the matrix: one row released, columns per lit, rows in turn
	task automatic scan(input logic [8:0] lit);
		int r;
		int prev;
		int dwell;
		int nchg;
		prev = -1;
		dwell = 0;
		nchg = 0;
		repeat (30) begin
			@(negedge clock_i);
			case (line_oe_o[2:0])
				3'b110: r = 0;
				3'b101: r = 1;
				3'b011: r = 2;
				default: r = 3;
			endcase
			check(8'(r == 3), 8'h00);
			check({2'h0, line_out_o}, 8'h00);
			if (r < 3)
				check({5'h00, line_oe_o[5:3]}, {5'h00, lit[3*r +: 3]});
			if (r != prev) begin
				if (nchg > 0)
					check(8'(r), 8'((prev + 1) % 3));
				if (nchg > 1)
					check(8'(dwell), 8'(ROWS));
				nchg++;
				dwell = 0;
			end
			dwell++;
			prev = r;
		end
	endtask

	// hang guard
	initial begin
		repeat (20000) @(posedge clock_i);
		fails++;
		tally_and_finish();
	end

	// ************************************************************
	// scenarios
	// ************************************************************
	initial begin
		rst_n_i = 1'b0;
		inputs_state_i = 8'h00;
		fault_event_i = 8'h00;
		secondary_cleared_i = 1'b0;
		repeat (8) @(posedge clock_i);
		rst_n_i <= 1'b1;
		// reset values, reserved bits, unmapped address
		rd(igc_pkg::OFF_GLOBAL, 8'h10);
		rd(igc_pkg::OFF_INDICATOR, 8'h00);
		rd(8'h3a, 8'h00);
		wr(igc_pkg::OFF_GLOBAL, 8'h1f);
		rd(igc_pkg::OFF_GLOBAL, 8'h19);
		check(8'(filter_hold_o), 8'h01);
		check(8'(ref_short_detect_en_o), 8'h01);
		wr(igc_pkg::OFF_GLOBAL, 8'h10);
		check(8'(filter_hold_o), 8'h00);
		check(8'(ref_short_detect_en_o), 8'h00);
		// user matrix from random register bits
		repeat (2) begin
			d = rnd();
			wr(igc_pkg::OFF_INDICATOR, d[7:0]);
			wr(igc_pkg::OFF_GLOBAL, {2'b00, d[8], 5'h10});
			scan(d[8:0]);
		end
		// autonomous: inputs drive one to eight, supply-low flag the ninth
		pulse_fault(8'h04);
		inputs_state_i <= 8'(rnd());
		wr(igc_pkg::OFF_GLOBAL, 8'h50);
		scan({1'b1, inputs_state_i});
		rd(igc_pkg::OFF_PRIMARY_FAULT, 8'h04);
		inputs_state_i <= 8'(rnd());
		wr(igc_pkg::OFF_GLOBAL, 8'h70);
		scan({1'b0, inputs_state_i});
		// push-pull lines follow bits zero to five
		repeat (3) begin
			d = rnd();
			wr(igc_pkg::OFF_INDICATOR, d[7:0]);
			// autonomous select and ninth bit random: both must be ignored here
			wr(igc_pkg::OFF_GLOBAL, {1'b1, d[9:8], 5'h10});
			@(negedge clock_i);
			check({2'h0, line_oe_o}, 8'h3f);
			check({2'h0, line_out_o}, {2'h0, d[5:0]});
		end
		// policy zero: good command clears all but thermal and summary
		wr(igc_pkg::OFF_GLOBAL, 8'h00);
		pulse_fault(8'h07);
		check(primary_fault_o, 8'h07);
		rd(igc_pkg::OFF_PRIMARY_FAULT, 8'h07);
		repeat (2) @(posedge clock_i);
		check(primary_fault_o, 8'h03);
		@(posedge clock_i);
		secondary_cleared_i <= 1'b1;
		@(posedge clock_i);
		secondary_cleared_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		check(primary_fault_o, 8'h01);
		// policy one: only a primary read clears
		wr(igc_pkg::OFF_GLOBAL, 8'h10);
		pulse_fault(8'h04);
		wr(8'h3a, 8'h55);
		check(primary_fault_o, 8'h05);
		rd(igc_pkg::OFF_PRIMARY_FAULT, 8'h05);
		repeat (2) @(posedge clock_i);
		check(primary_fault_o, 8'h00);
		tally_and_finish();
	end
endmodule // indicator_and_global_config_test

`default_nettype wire
